/* hdl/cml_pkg.sv */
// Shared constants and types for the code memory protection block.
package cml_pkg;

    // ********************************************************************
    // Array geometry
    // ********************************************************************
    localparam int CODE_BYTES = 8192;
    localparam int ENC_BYTES = 64;
    localparam int CODE_AW = 13;
    localparam int ENC_AW = 6;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [2:0] LOCK_ERASED = 3'h0;

    // ********************************************************************
    // Set-up patterns on {ctrl_a, data_en_b, ctrl_c, ctrl_d, ctrl_e}
    // ********************************************************************
    localparam logic [4:0] SEL_PROG_CODE = 5'h0F;
    localparam logic [4:0] SEL_VERIFY = 5'h03;
    localparam logic [4:0] SEL_PROG_ENC = 5'h0D;
    localparam logic [4:0] SEL_SIG_READ = 5'h00;
    localparam logic [4:0] SEL_LOCK_FIRST = 5'h1F;
    localparam logic [4:0] SEL_LOCK_SECOND = 5'h1C;
    localparam logic [4:0] SEL_LOCK_THIRD = 5'h16;

    // ********************************************************************
    // Signature locations
    // ********************************************************************
    localparam logic [12:0] SIG_LOC_0 = 13'h0030;
    localparam logic [12:0] SIG_LOC_1 = 13'h0031;
    localparam logic [12:0] SIG_LOC_2 = 13'h0060;
    localparam logic [12:0] SIG_LOC_3 = 13'h0061;

    // ********************************************************************
    // Register map
    // ********************************************************************
    localparam logic [31:0] REG_CTRL_OFS = 32'h0000_0000;
    localparam logic [31:0] REG_STATUS_OFS = 32'h0000_0004;
    localparam int CTRL_ERASE_BIT = 0;
    localparam int CTRL_CLR_REFUSED_BIT = 1;
    localparam int STAT_LEVEL_LSB = 0;
    localparam int STAT_LOCK_LSB = 4;
    localparam int STAT_EA_EFF_BIT = 8;
    localparam int STAT_EA_LATCH_BIT = 9;
    localparam int STAT_REFUSED_BIT = 10;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

    typedef enum logic [3:0] {
        SEC_L1 = 4'h1,
        SEC_L2 = 4'h2,
        SEC_L3 = 4'h4,
        SEC_L4 = 4'h8
    } sec_level_type;

    typedef struct packed {
        logic setup_rst;
        logic [4:0] ctrl;
        logic prog_strobe_b;
        logic vpp_high;
        logic [12:0] addr;
        logic [7:0] data;
    } prog_pins_type;

    typedef struct packed {
        logic req;
        logic table_read;
        logic from_ext;
        logic [15:0] addr;
    } fetch_req_type;

    typedef struct packed {
        logic valid;
        logic blocked;
        logic external;
        logic [7:0] data;
    } fetch_rsp_type;

endpackage

/* hdl/cml_sync2.sv */
// Two-stage synchroniser for pin inputs.
`timescale 1ns/100ps
module cml_sync2 #(
    parameter int W = 1
) (
    input logic clk_i,
    input logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    // No reset, so the chain already tracks the pins while reset is held.
    logic [W-1:0] stage;

    always_ff @(posedge clk_i) begin
        stage <= d_i;
        q_o <= stage;
    end
endmodule

/* hdl/cml_code_lock.sv */
// Program memory arrays with encryption, lock levels and an AHB-Lite status port.
`timescale 1ns/100ps
// Function
// - Encryption array holds 64 bytes, all ones when erased.
// - Six address lines select the encryption byte during verify.
// - Verify byte is code byte XNOR selected encryption byte.
// - Erased encryption array returns code bytes unchanged on verify.
// - 8 Kbyte code array plus 4-byte fixed signature array.
// - Level 1 enables no lock, yet verify stays encrypted.
// - Level 1 external table reads return plain internal code.
// - Level 2 blocks external table reads from internal code.
// - Level 2 and up latch the external access pin at reset.
// - Level 2 and up refuse further array programming.
// - Level 3 adds disabled verify read-out.
// - Level 4 adds blocked external program execution.
// - Signature bytes read at 30h, 31h, 60h, 61h with signature pattern.
// - No direct read path exists for the encryption array.
// - Erase returns code and encryption bytes to all ones and lock bits to zero.
module cml_code_lock #(
    parameter logic [7:0] SIG_BYTE_0 = 8'h11, // Arbitrary value.
    parameter logic [7:0] SIG_BYTE_1 = 8'h22, // Arbitrary value.
    parameter logic [7:0] SIG_BYTE_2 = 8'h33, // Arbitrary value.
    parameter logic [7:0] SIG_BYTE_3 = 8'h44  // Arbitrary value.
) (
    input logic CLOCK_I,
    input logic RST_B_I,
    input logic HSEL_I,
    input logic [31:0] HADDR_I,
    input logic [1:0] HTRANS_I,
    input logic HWRITE_I,
    input logic [2:0] HSIZE_I,
    input logic HREADY_I,
    input logic [31:0] HWDATA_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    input cml_pkg::prog_pins_type PROG_PINS_I,
    output logic [7:0] PROG_DATA_O,
    output logic PROG_DATA_OE_O,
    input logic EXTERNAL_ACCESS_PIN_I,
    input cml_pkg::fetch_req_type FETCH_REQ_I,
    output cml_pkg::fetch_rsp_type FETCH_RSP_O
);

    // ********************************************************************
    // Non-volatile storage
    // ********************************************************************
    // Cells keep their contents across reset; only an erase restores them.
    logic [7:0] code_mem [cml_pkg::CODE_BYTES] = '{default: cml_pkg::ERASED_BYTE};
    logic [7:0] enc_mem [cml_pkg::ENC_BYTES] = '{default: cml_pkg::ERASED_BYTE};
    logic [2:0] lock_prog = cml_pkg::LOCK_ERASED;

    // ********************************************************************
    // Pin synchronisers and set-up decode
    // ********************************************************************
    cml_pkg::prog_pins_type pins;
    logic ea_sync;
    logic prev_strobe_b;
    logic ea_captured;
    logic ea_latched;
    logic refused_flag;
    logic wr_pend;
    logic [31:0] wr_addr;

    cml_sync2 #(.W($bits(cml_pkg::prog_pins_type))) u_sync_pins (
        .clk_i(CLOCK_I),
        .d_i(PROG_PINS_I),
        .q_o(pins)
    );

    cml_sync2 #(.W(1)) u_sync_ea (
        .clk_i(CLOCK_I),
        .d_i(EXTERNAL_ACCESS_PIN_I),
        .q_o(ea_sync)
    );

    wire mode_prog_code = pins.setup_rst && pins.ctrl == cml_pkg::SEL_PROG_CODE;
    wire mode_prog_enc = pins.setup_rst && pins.ctrl == cml_pkg::SEL_PROG_ENC;
    wire mode_verify = pins.setup_rst && pins.ctrl == cml_pkg::SEL_VERIFY;
    wire mode_sig = pins.setup_rst && pins.ctrl == cml_pkg::SEL_SIG_READ;
    wire mode_lock1 = pins.setup_rst && pins.ctrl == cml_pkg::SEL_LOCK_FIRST;
    wire mode_lock2 = pins.setup_rst && pins.ctrl == cml_pkg::SEL_LOCK_SECOND;
    wire mode_lock3 = pins.setup_rst && pins.ctrl == cml_pkg::SEL_LOCK_THIRD;
    wire prog_event = prev_strobe_b && !pins.prog_strobe_b && pins.vpp_high;

    // ********************************************************************
    // Security level
    // ********************************************************************
    cml_pkg::sec_level_type level;
    assign level = lock_prog[2] ? cml_pkg::SEC_L4 :
                   lock_prog[1] ? cml_pkg::SEC_L3 :
                   lock_prog[0] ? cml_pkg::SEC_L2 :
                   cml_pkg::SEC_L1;
    wire at_least_2 = level != cml_pkg::SEC_L1;
    wire at_least_3 = level == cml_pkg::SEC_L3 || level == cml_pkg::SEC_L4;
    wire at_level_4 = level == cml_pkg::SEC_L4;

    // ********************************************************************
    // Programming
    // ********************************************************************
    // Lock bits stay programmable at every level so protection can only grow.
    // A refused cell write sets a sticky flag, so the programmer can tell why verify disagrees.
    wire wr_code = prog_event && mode_prog_code && !at_least_2;
    wire wr_enc = prog_event && mode_prog_enc && !at_least_2;
    wire refused = prog_event && (mode_prog_code || mode_prog_enc) && at_least_2;
    wire [2:0] lock_set = {mode_lock3, mode_lock2, mode_lock1} & {3{prog_event}};
    wire [7:0] code_rd = code_mem[pins.addr];
    wire [7:0] enc_rd = enc_mem[pins.addr[cml_pkg::ENC_AW-1:0]];
    wire wr_ctrl = wr_pend && wr_addr == cml_pkg::REG_CTRL_OFS;
    wire erase_go = wr_ctrl && HWDATA_I[cml_pkg::CTRL_ERASE_BIT];
    wire refused_clr = wr_ctrl && HWDATA_I[cml_pkg::CTRL_CLR_REFUSED_BIT];

    // Array programming only clears bits, as an EPROM cell does.
    always_ff @(posedge CLOCK_I) begin
        if (erase_go) begin
            for (int i = 0; i < cml_pkg::CODE_BYTES; i++) begin
                code_mem[i] <= cml_pkg::ERASED_BYTE;
            end
            for (int j = 0; j < cml_pkg::ENC_BYTES; j++) begin
                enc_mem[j] <= cml_pkg::ERASED_BYTE;
            end
            lock_prog <= cml_pkg::LOCK_ERASED;
        end else begin
            if (wr_code) begin
                code_mem[pins.addr] <= code_rd & pins.data;
            end
            if (wr_enc) begin
                enc_mem[pins.addr[cml_pkg::ENC_AW-1:0]] <= enc_rd & pins.data;
            end
            lock_prog <= lock_prog | lock_set;
        end
    end

    // ********************************************************************
    // Verify and signature read-out
    // ********************************************************************
    // The encryption array is only ever seen folded into a code byte.
    wire [7:0] verify_byte = ~(code_rd ^ enc_rd);
    wire verify_ok = mode_verify && !at_least_3;
    wire sig_hit0 = pins.addr == cml_pkg::SIG_LOC_0;
    wire sig_hit1 = pins.addr == cml_pkg::SIG_LOC_1;
    wire sig_hit2 = pins.addr == cml_pkg::SIG_LOC_2;
    wire sig_hit3 = pins.addr == cml_pkg::SIG_LOC_3;
    wire sig_hit = sig_hit0 || sig_hit1 || sig_hit2 || sig_hit3;
    wire [7:0] sig_byte = sig_hit0 ? SIG_BYTE_0 :
                          sig_hit1 ? SIG_BYTE_1 :
                          sig_hit2 ? SIG_BYTE_2 :
                          sig_hit3 ? SIG_BYTE_3 : cml_pkg::ERASED_BYTE;
    wire sig_ok = mode_sig && sig_hit;
    wire [7:0] next_data = verify_ok ? verify_byte : sig_ok ? sig_byte : cml_pkg::ERASED_BYTE;
    wire next_oe = verify_ok || sig_ok;

    always_ff @(posedge CLOCK_I) begin
        if (!RST_B_I) begin
            PROG_DATA_O <= cml_pkg::ERASED_BYTE;
            PROG_DATA_OE_O <= 1'b0;
            prev_strobe_b <= 1'b1;
        end else begin
            PROG_DATA_O <= next_data;
            PROG_DATA_OE_O <= next_oe;
            prev_strobe_b <= pins.prog_strobe_b;
        end
    end

    // ********************************************************************
    // External access latch and fetch path
    // ********************************************************************
    // Capture happens on the first edge after release, from the synchronised pin.
    always_ff @(posedge CLOCK_I) begin
        if (!RST_B_I) begin
            ea_captured <= 1'b0;
            ea_latched <= 1'b0;
        end else if (!ea_captured) begin
            ea_captured <= 1'b1;
            ea_latched <= ea_sync;
        end
    end

    wire ea_eff = at_least_2 ? ea_latched : ea_sync;
    wire tgt_internal = ea_eff && FETCH_REQ_I.addr[15:cml_pkg::CODE_AW] == 3'h0;
    wire [7:0] fetch_code_rd = code_mem[FETCH_REQ_I.addr[cml_pkg::CODE_AW-1:0]];
    // Table reads from inside the array are never stopped, only those run from outside.
    wire blk_table = FETCH_REQ_I.table_read && FETCH_REQ_I.from_ext && tgt_internal
                     && at_least_2;
    wire blk_exec = !FETCH_REQ_I.table_read && !tgt_internal && at_level_4;
    wire fetch_blocked = blk_table || blk_exec;
    wire [7:0] next_fetch_data = (fetch_blocked || !tgt_internal) ? cml_pkg::ERASED_BYTE
                                 : fetch_code_rd;

    always_ff @(posedge CLOCK_I) begin
        if (!RST_B_I) begin
            FETCH_RSP_O <= '0;
        end else begin
            FETCH_RSP_O.valid <= FETCH_REQ_I.req;
            FETCH_RSP_O.blocked <= FETCH_REQ_I.req && fetch_blocked;
            FETCH_RSP_O.external <= FETCH_REQ_I.req && !tgt_internal;
            FETCH_RSP_O.data <= next_fetch_data;
        end
    end

    // ********************************************************************
    // AHB-Lite slave
    // ********************************************************************
    // Zero wait states: read data is prepared in the address phase.
    wire ahb_take = HSEL_I && HREADY_I && HTRANS_I[1];
    // Fields are placed by the shared positions, so the map lives in one place.
    logic [31:0] status_word;
    always_comb begin
        status_word = cml_pkg::RDATA_RESET;
        status_word[cml_pkg::STAT_LEVEL_LSB +: 4] = level;
        status_word[cml_pkg::STAT_LOCK_LSB +: 3] = lock_prog;
        status_word[cml_pkg::STAT_EA_EFF_BIT] = ea_eff;
        status_word[cml_pkg::STAT_EA_LATCH_BIT] = ea_latched;
        status_word[cml_pkg::STAT_REFUSED_BIT] = refused_flag;
    end
    wire [31:0] next_rdata = (ahb_take && !HWRITE_I && HADDR_I == cml_pkg::REG_STATUS_OFS)
                             ? status_word : cml_pkg::RDATA_RESET;

    always_ff @(posedge CLOCK_I) begin
        if (!RST_B_I) begin
            wr_pend <= 1'b0;
            wr_addr <= cml_pkg::REG_CTRL_OFS;
            HRDATA_O <= cml_pkg::RDATA_RESET;
            HREADYOUT_O <= 1'b1;
            HRESP_O <= 1'b0;
            refused_flag <= 1'b0;
        end else begin
            wr_pend <= ahb_take && HWRITE_I;
            wr_addr <= HADDR_I;
            HRDATA_O <= next_rdata;
            HREADYOUT_O <= 1'b1;
            HRESP_O <= 1'b0;
            // A refusal in the cycle of a clear wins, so none is ever lost.
            refused_flag <= refused || (refused_flag && !refused_clr);
        end
    end

    // ********************************************************************
    // Assertions
    // ********************************************************************
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RST_B_I);
    // Checks watch the synchronised pins, so they lag the package pins by two cycles.

    a_level_order: assert property ($rose(lock_prog[1]) |-> at_least_3 && at_least_2)
        else $error("Second lock bit did not raise level.");
    a_verify_xnor: assert property (verify_ok |=> PROG_DATA_OE_O
        && PROG_DATA_O == ~($past(code_rd) ^ $past(enc_rd)))
        else $error("Verify byte is not code XNOR encryption.");
    a_verify_plain: assert property ((verify_ok && enc_rd == 8'hFF)
        |=> PROG_DATA_O == $past(code_rd))
        else $error("Erased encryption byte altered verify.");
    a_verify_block: assert property ((mode_verify && at_least_3) |=> !PROG_DATA_OE_O)
        else $error("Verify driven at level 3 or above.");
    a_sig_read: assert property ((mode_sig && pins.addr == cml_pkg::SIG_LOC_2)
        |=> PROG_DATA_OE_O && PROG_DATA_O == SIG_BYTE_2)
        else $error("Signature byte wrong.");
    a_table_block: assert property ((FETCH_REQ_I.req && blk_table)
        |=> FETCH_RSP_O.blocked && FETCH_RSP_O.data == 8'hFF)
        else $error("External table read reached internal code.");
    a_table_plain: assert property ((FETCH_REQ_I.req && FETCH_REQ_I.table_read
        && tgt_internal && !at_least_2) |=> !FETCH_RSP_O.blocked
        && FETCH_RSP_O.data == $past(fetch_code_rd))
        else $error("Level 1 table read not plain.");
    a_ext_exec: assert property ((FETCH_REQ_I.req && !FETCH_REQ_I.table_read
        && !tgt_internal && level == cml_pkg::SEC_L4) |=> FETCH_RSP_O.blocked)
        else $error("External execution allowed at level 4.");
    a_ea_hold: assert property ((ea_captured && $past(ea_captured))
        |-> $stable(ea_latched))
        else $error("Latched access pin changed after reset.");
    a_prog_refuse: assert property ((prog_event && mode_prog_code && at_least_2
        && !erase_go) ##1 $stable(pins.addr) |-> $stable(code_rd) && refused_flag)
        else $error("Programming accepted at level 2 or above.");
    a_erase_all: assert property (erase_go |=> lock_prog == 3'h0
        && code_rd == 8'hFF && enc_rd == 8'hFF && level == cml_pkg::SEC_L1)
        else $error("Erase left programmed cells.");
    a_verify_level1: assert property ((mode_verify && level == cml_pkg::SEC_L1)
        |=> PROG_DATA_OE_O)
        else $error("Verify silent at level 1.");
    a_sig_silent: assert property ((mode_sig && !sig_hit) |=> !PROG_DATA_OE_O)
        else $error("Signature driven at an empty location.");
    a_table_own: assert property ((FETCH_REQ_I.req && FETCH_REQ_I.table_read
        && !FETCH_REQ_I.from_ext && tgt_internal) |=> !FETCH_RSP_O.blocked
        && FETCH_RSP_O.data == $past(fetch_code_rd))
        else $error("Internal table read was blocked.");
    a_exec_open: assert property ((FETCH_REQ_I.req && !FETCH_REQ_I.table_read
        && !at_level_4) |=> !FETCH_RSP_O.blocked)
        else $error("Execution blocked below level 4.");
    a_refuse_flag: assert property (refused |=> refused_flag)
        else $error("Refused write left no flag.");
    a_enc_refuse: assert property ((prog_event && mode_prog_enc && at_least_2
        && !erase_go) ##1 $stable(pins.addr) |-> $stable(enc_rd))
        else $error("Encryption write accepted at level 2 or above.");
    a_lock_sticky: assert property (!erase_go
        |=> (lock_prog & $past(lock_prog)) == $past(lock_prog))
        else $error("Lock bit cleared without an erase.");

    c_verify_enc: cover property (verify_ok && enc_rd != 8'hFF);
    c_refused: cover property (refused);
    c_table_blk: cover property (FETCH_REQ_I.req && blk_table);
    c_erase: cover property (erase_go && lock_prog != 3'h0);
    c_sig_read: cover property (sig_ok);

endmodule

/* testbench/cml_prog_model.sv */
// Programmer and verifier model that drives the programming pins of the protection block.
`timescale 1ns/100ps
module cml_prog_model (
    input wire logic clk_i,
    input wire logic [7:0] dut_data_i,
    input wire logic dut_oe_i,
    output cml_pkg::prog_pins_type pins_o
);
    cml_pkg::prog_pins_type p;
    logic [7:0] drv;
    logic drv_en;

    // ********************************************************************
    // Data pins
    // ********************************************************************
    // Released lines show the inverse of the last value, so stale data never passes as valid.
    always_comb begin
        pins_o = p;
        pins_o.data = dut_oe_i ? dut_data_i : (drv_en ? drv : ~drv);
    end

    initial begin
        p = '0;
        p.prog_strobe_b = 1'b1;
        drv = 8'h00;
        drv_en = 1'b0;
    end

    // ********************************************************************
    // Access tasks
    // ********************************************************************
    // Pins settle before the strobe and stay after it, because the block synchronises them.
    task automatic prog_byte(input logic [4:0] sel, input logic [12:0] a, input logic [7:0] dat);
        p.setup_rst <= 1'b1;
        p.ctrl <= sel;
        p.addr <= a;
        p.vpp_high <= 1'b1;
        drv <= dat;
        drv_en <= 1'b1;
        repeat (4) @(posedge clk_i);
        p.prog_strobe_b <= 1'b0;
        repeat (3) @(posedge clk_i);
        p.prog_strobe_b <= 1'b1;
        repeat (3) @(posedge clk_i);
        p.vpp_high <= 1'b0;
        drv_en <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic verify(input logic [4:0] sel, input logic [12:0] a, output logic [7:0] d,
                          output logic oe);
        p.setup_rst <= 1'b1;
        p.ctrl <= sel;
        p.addr <= a;
        p.vpp_high <= 1'b0;
        drv_en <= 1'b0;
        repeat (5) @(posedge clk_i);
        d = dut_data_i;
        oe = dut_oe_i;
    endtask
endmodule

/* testbench/code_memory_lock_encryption_tb_top.sv */
// Self-checking testbench for the code memory protection block.
`timescale 1ns/100ps
module code_memory_lock_encryption_tb_top;
    localparam logic [31:0] SIG = 32'h4433_2211; // Arbitrary values.
    logic clk, rst_b, hsel, hwrite, ea, oe, hready, hresp;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [7:0] pdat;
    logic [12:0] locs [4];
    cml_pkg::prog_pins_type pins;
    cml_pkg::fetch_req_type freq;
    cml_pkg::fetch_rsp_type frsp;
    int error_cnt, samples_checked;

    cml_code_lock #(.SIG_BYTE_0(SIG[7:0]), .SIG_BYTE_1(SIG[15:8]), .SIG_BYTE_2(SIG[23:16]),
                    .SIG_BYTE_3(SIG[31:24])) u_cml_code_lock (
        .CLOCK_I(clk), .RST_B_I(rst_b), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
        .HWRITE_I(hwrite), .HSIZE_I(hsize), .HREADY_I(hready), .HWDATA_I(hwdata),
        .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp), .PROG_PINS_I(pins),
        .PROG_DATA_O(pdat), .PROG_DATA_OE_O(oe), .EXTERNAL_ACCESS_PIN_I(ea),
        .FETCH_REQ_I(freq), .FETCH_RSP_O(frsp));
    cml_prog_model u_cml_prog_model (.clk_i(clk), .dut_data_i(pdat), .dut_oe_i(oe),
                                     .pins_o(pins));

    // ********************************************************************
    // Tasks
    // ********************************************************************
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] r);
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        r = hrdata;
    endtask

    task automatic st(input logic [31:0] e);
        ahb(1'b0, cml_pkg::REG_STATUS_OFS, 32'h0000_0000, rd);
        chk("status", e, rd);
        chk("hresp", 32'h0000_0000, {31'h0, hresp});
    endtask

    task automatic vfy(input logic [4:0] s, input logic [12:0] a, input logic [31:0] e);
        logic [7:0] d;
        logic o;
        u_cml_prog_model.verify(s, a, d, o);
        chk("verify", e, {23'h0, o, d});
    endtask

    task automatic fch(input logic t, input logic x, input logic [15:0] a,
                       input logic [31:0] e);
        cml_pkg::fetch_rsp_type r;
        freq <= '{req: 1'b1, table_read: t, from_ext: x, addr: a};
        @(posedge clk);
        freq.req <= 1'b0;
        @(posedge clk);
        r = frsp;
        chk("fetch", e, {21'h0, r});
    endtask

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ********************************************************************
    // Clock, watchdog and tests
    // ********************************************************************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // The whole sequence needs well under a thousand cycles.
    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        finish_test;
    end

    initial begin
        rst_b = 1'b0;
        hsel = 1'b1;
        hsize = 3'h2;
        hwrite = 1'b0;
        htrans = 2'h0;
        haddr = 32'h0000_0000;
        hwdata = 32'h0000_0000;
        ea = 1'b1;
        freq = '0;
        locs = '{cml_pkg::SIG_LOC_0, cml_pkg::SIG_LOC_1, cml_pkg::SIG_LOC_2, cml_pkg::SIG_LOC_3};
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 4; i++) begin
            vfy(cml_pkg::SEL_SIG_READ, locs[i], {23'h0, 1'b1, SIG[8*i+:8]});
        end
        vfy(cml_pkg::SEL_SIG_READ, 13'h0032, 32'h0000_00FF);
        vfy(cml_pkg::SEL_VERIFY, 13'h1FFF, 32'h0000_01FF);
        st(32'h0000_0301);
        u_cml_prog_model.prog_byte(cml_pkg::SEL_PROG_CODE, 13'h0045, 8'h5A);
        vfy(cml_pkg::SEL_VERIFY, 13'h0045, 32'h0000_015A);
        fch(1'b1, 1'b1, 16'h0045, 32'h0000_045A);
        u_cml_prog_model.prog_byte(cml_pkg::SEL_PROG_ENC, 13'h0005, 8'h0F);
        vfy(cml_pkg::SEL_VERIFY, 13'h0045, 32'h0000_01AA);
        vfy(cml_pkg::SEL_VERIFY, 13'h1FC5, 32'h0000_010F);
        fch(1'b1, 1'b1, 16'h0005, 32'h0000_04FF);
        // Locking only after the contents were verified.
        u_cml_prog_model.prog_byte(cml_pkg::SEL_LOCK_FIRST, 13'h0000, 8'h00);
        st(32'h0000_0312);
        fch(1'b1, 1'b1, 16'h0045, 32'h0000_06FF);
        fch(1'b1, 1'b0, 16'h0045, 32'h0000_045A);
        u_cml_prog_model.prog_byte(cml_pkg::SEL_PROG_CODE, 13'h0045, 8'h00);
        u_cml_prog_model.prog_byte(cml_pkg::SEL_PROG_ENC, 13'h0005, 8'h00);
        ea <= 1'b0;
        vfy(cml_pkg::SEL_VERIFY, 13'h0045, 32'h0000_01AA);
        st(32'h0000_0712);
        u_cml_prog_model.prog_byte(cml_pkg::SEL_LOCK_SECOND, 13'h0000, 8'h00);
        st(32'h0000_0734);
        fch(1'b0, 1'b1, 16'h3000, 32'h0000_05FF);
        vfy(cml_pkg::SEL_VERIFY, 13'h0045, 32'h0000_00FF);
        u_cml_prog_model.prog_byte(cml_pkg::SEL_LOCK_THIRD, 13'h0000, 8'h00);
        st(32'h0000_0778);
        fch(1'b0, 1'b1, 16'h3000, 32'h0000_07FF);
        fch(1'b0, 1'b0, 16'h0045, 32'h0000_045A);
        ahb(1'b1, cml_pkg::REG_CTRL_OFS, 32'h0000_0001, rd);
        st(32'h0000_0601);
        vfy(cml_pkg::SEL_VERIFY, 13'h0045, 32'h0000_01FF);
        ahb(1'b1, cml_pkg::REG_CTRL_OFS, 32'h0000_0002, rd);
        st(32'h0000_0201);
        ahb(1'b0, 32'h0000_0010, 32'h0000_0000, rd);
        chk("unmapped", 32'h0000_0000, rd);
        finish_test;
    end
endmodule
